// ### rtl/rshc_core.sv
`timescale 1ns/1ps
`include "rshc_map.svh"
module rshc_core #(
  parameter int SEGS      = 10,
  parameter int BLINK_CYC = `RSHC_BLINK_CYC
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [4:0]        addr,
  input  wire logic [15:0]       wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [15:0]       rdata,
  input  wire logic              smp_valid,
  output logic                   smp_ready,
  input  wire logic              smp_chan,
  input  wire logic [15:0]       smp_data,
  input  wire logic [2:0]        smp_unit,
  input  wire logic signed [7:0] pid_out,
  input  wire logic              power_fail,
  output logic      [1:0]        filt_led,
  output logic      [9:0]        gain_out,
  output logic      [9:0]        rate_tc_s,
  output logic      [9:0]        int_tc_s,
  output logic      [15:0]       setpoint_out,
  output logic                   ctrl_chan,
  output logic      [19:0]       heater_pwr,
  output logic      [SEGS-1:0]   bar_blink
);
  typedef struct packed {
    rshc_pkg::rshc_state_t st;
    logic                  ch;
    logic [15:0]           raw;
    logic [2:0]            unit;
    logic [4:0]            base;
    logic [1:0][3:0]       ptr;
    logic [1:0][3:0]       cnt;
    logic [1:0][19:0]      sum;
    logic                  pf1;
    logic                  pf2;
    logic                  stats_en;
    logic [1:0]            filt_en;
    logic [1:0]            dchan;
    logic                  cchan;
    logic [9:0]            gain;
    logic [9:0]            rate;
    logic [9:0]            rset;
    logic [9:0]            itc;
    logic [15:0]           sp;
    logic [6:0]            manual;
    logic [2:0]            range;
    logic [1:0][15:0]      rdg;
    logic [1:0][2:0]       runit;
    logic [1:0][15:0]      mx;
    logic [1:0][15:0]      mn;
    logic [1:0][15:0]      dv;
    logic [1:0]            seen;
    logic [15:0]           rd;
  } rshc_core_t;
  rshc_core_t s_reg, s_next;

  logic [4:0]         mem_raddr;
  logic [15:0]        mem_rdata;
  logic [15:0]        old;
  logic [19:0]        sum_new;
  logic [15:0]        avg;
  logic [15:0]        rv;
  logic [2:0]         cunit;
  logic signed [16:0] err;
  logic [15:0]        aerr;
  logic signed [16:0] spq;
  logic               do_clear;

  // ----------------------------------------
  // history of readings, ten per channel
  // ----------------------------------------
  rshc_hist #(
    .DEPTH (20),
    .AW    (5),
    .W     (16)
  ) u_hist (
    .clk   (clk),
    .reset (reset),
    .we    (s_reg.st == rshc_pkg::RSHC_RD),
    .waddr (s_reg.base),
    .wdata (s_reg.raw),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // read of the oldest entry is issued as the sample is taken
  assign mem_raddr = (smp_chan ? 5'h0A : 5'h00)
                   + {1'b0, s_reg.ptr[smp_chan]};
  assign smp_ready = (s_reg.st == rshc_pkg::RSHC_IDLE);

  // ----------------------------------------
  // datapath helpers
  // ----------------------------------------
  always_comb begin
    // an unfilled window contributes nothing from empty slots
    old = (s_reg.cnt[s_reg.ch] == `RSHC_FILT_N) ? mem_rdata : 16'h0000;
    sum_new = s_reg.sum[s_reg.ch] - {{4{old[15]}}, old}
            + {{4{s_reg.raw[15]}}, s_reg.raw};
    // mean over the readings held so far, at most ten
    avg = 16'($signed(s_reg.sum[s_reg.ch])
        / $signed({16'h0000, s_reg.cnt[s_reg.ch]}));
    rv = s_reg.filt_en[s_reg.ch] ? avg : s_reg.raw;
    cunit = (s_reg.ch == s_reg.cchan) ? s_reg.unit
          : s_reg.runit[s_reg.cchan];
    err = $signed({rv[15], rv}) - $signed({s_reg.sp[15], s_reg.sp});
    aerr = err[16] ? 16'(-err) : err[15:0];
    spq = $signed({wdata[15], wdata});
    if (cunit < rshc_pkg::RSHC_U_V) begin
      spq = spq - (spq % `RSHC_SP_Q);
    end
    do_clear = wr_en && addr == `RSHC_A_CMD && wdata[`RSHC_B_CLEAR];
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.pf1 = power_fail;
    s_next.pf2 = s_reg.pf1;
    s_next.rd = 16'h0000;
    // filter pipeline: take, read oldest, then publish
    unique case (s_reg.st)
      rshc_pkg::RSHC_IDLE: begin
        if (smp_valid) begin
          s_next.st   = rshc_pkg::RSHC_RD;
          s_next.ch   = smp_chan;
          s_next.raw  = smp_data;
          s_next.unit = smp_unit;
          s_next.base = mem_raddr;
        end
      end
      rshc_pkg::RSHC_RD: begin
        s_next.sum[s_reg.ch] = sum_new;
        s_next.ptr[s_reg.ch] = (s_reg.ptr[s_reg.ch] == `RSHC_FILT_N - 1)
                             ? 4'h0 : s_reg.ptr[s_reg.ch] + 4'h1;
        if (s_reg.cnt[s_reg.ch] != `RSHC_FILT_N) begin
          s_next.cnt[s_reg.ch] = s_reg.cnt[s_reg.ch] + 4'h1;
        end
        s_next.st = rshc_pkg::RSHC_UPD;
      end
      rshc_pkg::RSHC_UPD: begin
        s_next.rdg[s_reg.ch]   = rv;
        s_next.runit[s_reg.ch] = s_reg.unit;
        s_next.st = rshc_pkg::RSHC_IDLE;
        // a reading feeds each display that shows its channel
        for (int d = 0; d < 2; d++) begin
          if (s_reg.stats_en && s_reg.dchan[d] == s_reg.ch) begin
            if (!s_reg.seen[d] || $signed(rv) > $signed(s_reg.mx[d])) begin
              s_next.mx[d] = rv;
            end
            if (!s_reg.seen[d] || $signed(rv) < $signed(s_reg.mn[d])) begin
              s_next.mn[d] = rv;
            end
            if (s_reg.unit == cunit && aerr > s_reg.dv[d]) begin
              s_next.dv[d] = aerr;
            end
            s_next.seen[d] = 1'b1;
          end
        end
      end
    endcase
    // register writes
    if (wr_en) begin
      unique case (addr)
        `RSHC_A_CTRL: begin
          s_next.stats_en = wdata[`RSHC_B_STATS];
          s_next.filt_en  = wdata[`RSHC_B_FILT +: 2];
          s_next.dchan    = wdata[`RSHC_B_DISP +: 2];
          s_next.cchan    = wdata[`RSHC_B_CCH];
        end
        `RSHC_A_GAIN: s_next.gain = (wdata > 16'(`RSHC_GAIN_MAX))
                      ? `RSHC_GAIN_MAX : wdata[9:0];
        `RSHC_A_RATE: s_next.rate = (wdata > 16'(`RSHC_RATE_MAX))
                      ? `RSHC_RATE_MAX : wdata[9:0];
        `RSHC_A_RSET: s_next.rset = (wdata > 16'(`RSHC_GAIN_MAX))
                      ? `RSHC_GAIN_MAX : wdata[9:0];
        `RSHC_A_SETPT: s_next.sp = spq[15:0];
        `RSHC_A_MAN: s_next.manual = (wdata > 16'h0064)
                     ? 7'h64 : wdata[6:0];
        `RSHC_A_RANGE: s_next.range = (wdata > 16'h0005)
                       ? 3'h0 : wdata[2:0];
        default: ;
      endcase
    end
    // integrator time from repeats per thousand seconds
    if (s_reg.rset == 10'h000) begin
      s_next.itc = 10'h000;
    end else if (`RSHC_ITC_NUM / s_reg.rset > `RSHC_ITC_MAX) begin
      s_next.itc = `RSHC_ITC_MAX;
    end else begin
      s_next.itc = 10'(`RSHC_ITC_NUM / s_reg.rset);
    end
    // clear keeps the enable; it wins over a same-cycle update
    if (do_clear) begin
      s_next.mx = '0;
      s_next.mn = '0;
      s_next.dv = '0;
      s_next.seen = 2'b00;
    end
    // power loss drops the statistics gathered so far and their enable
    if (s_reg.pf2) begin
      s_next.stats_en = 1'b0;
      s_next.mx = '0;
      s_next.mn = '0;
      s_next.dv = '0;
      s_next.seen = 2'b00;
    end
    // read data, one cycle after the strobe
    if (rd_en) begin
      if (addr >= `RSHC_A_STAT0 && addr < `RSHC_A_RDGA) begin
        unique case (3'(addr - `RSHC_A_STAT0))
          3'h0: s_next.rd = s_reg.mx[0];
          3'h1: s_next.rd = s_reg.mn[0];
          3'h2: s_next.rd = s_reg.dv[0];
          3'h3: s_next.rd = s_reg.mx[1];
          3'h4: s_next.rd = s_reg.mn[1];
          default: s_next.rd = s_reg.dv[1];
        endcase
      end else begin
        unique case (addr)
          `RSHC_A_CTRL:  s_next.rd = {10'h000, s_reg.cchan, s_reg.dchan,
                                      s_reg.filt_en, s_reg.stats_en};
          `RSHC_A_GAIN:  s_next.rd = {6'h00, s_reg.gain};
          `RSHC_A_RATE:  s_next.rd = {6'h00, s_reg.rate};
          `RSHC_A_RSET:  s_next.rd = {6'h00, s_reg.rset};
          `RSHC_A_SETPT: s_next.rd = s_reg.sp;
          `RSHC_A_MAN:   s_next.rd = {9'h000, s_reg.manual};
          `RSHC_A_RANGE: s_next.rd = {13'h0000, s_reg.range};
          `RSHC_A_RDGA:  s_next.rd = s_reg.rdg[0];
          `RSHC_A_RDGB:  s_next.rd = s_reg.rdg[1];
          `RSHC_A_INFO:  s_next.rd = {s_reg.runit[1], s_reg.runit[0],
                                      s_reg.itc};
          default:       s_next.rd = 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.st <= rshc_pkg::RSHC_IDLE;
      s_reg.gain <= `RSHC_RST_GAIN;
      s_reg.manual <= `RSHC_RST_MAN;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // heater stage
  // ----------------------------------------
  rshc_heater #(
    .SEGS      (SEGS),
    .BLINK_CYC (BLINK_CYC)
  ) u_heater (
    .clk        (clk),
    .reset      (reset),
    .gain_zero  (s_reg.gain == 10'h000),
    .manual     (s_reg.manual),
    .pid_out    (pid_out),
    .range      (s_reg.range),
    .heater_pwr (heater_pwr),
    .bar_blink  (bar_blink)
  );

  // lamp follows the channel, not the display position
  assign filt_led[0] = s_reg.filt_en[s_reg.dchan[0]];
  assign filt_led[1] = s_reg.filt_en[s_reg.dchan[1]];
  assign rdata        = s_reg.rd;
  assign gain_out     = s_reg.gain;
  assign rate_tc_s    = s_reg.rate;
  assign int_tc_s     = s_reg.itc;
  assign setpoint_out = s_reg.sp;
  assign ctrl_chan    = s_reg.cchan;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_led;
    @(posedge clk) disable iff (reset)
      filt_led[0] == (s_reg.dchan[0] ? s_reg.filt_en[1] : s_reg.filt_en[0])
      && filt_led[1] == (s_reg.dchan[1] ? s_reg.filt_en[1] : s_reg.filt_en[0]);
  endproperty
  a_led: assert property (p_led) else $error("filter lamp wrong");

  property p_freeze;
    @(posedge clk) disable iff (reset)
      !s_reg.stats_en && !do_clear && !s_reg.pf2
      |=> $stable(s_reg.mx) && $stable(s_reg.mn) && $stable(s_reg.dv);
  endproperty
  a_freeze: assert property (p_freeze) else $error("stats moved");

  property p_clear;
    @(posedge clk) disable iff (reset)
      do_clear && !s_reg.pf2
      |=> s_reg.mx == '0 && s_reg.mn == '0 && s_reg.dv == '0
          && s_reg.stats_en == $past(s_reg.stats_en);
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_pf;
    @(posedge clk) disable iff (reset)
      power_fail ##1 power_fail |=> ##1 !s_reg.stats_en && s_reg.mn == '0;
  endproperty
  a_pf: assert property (p_pf) else $error("stats survive power loss");

  property p_gain;
    @(posedge clk) disable iff (reset)
      wr_en && addr == `RSHC_A_GAIN && wdata > 16'h03E7
      |=> gain_out == 10'h3E7;
  endproperty
  a_gain: assert property (p_gain) else $error("gain over range");

  property p_itc;
    @(posedge clk) disable iff (reset)
      s_reg.rset == 10'h014 ##1 s_reg.rset == 10'h014 |-> int_tc_s == 10'h032;
  endproperty
  a_itc: assert property (p_itc) else $error("integrator time");

  property p_sp;
    @(posedge clk) disable iff (reset)
      wr_en && addr == `RSHC_A_SETPT && cunit < 3'h3
      |=> $signed(setpoint_out) % 100 == 0;
  endproperty
  a_sp: assert property (p_sp) else $error("setpoint not quantised");

  property p_max;
    @(posedge clk) disable iff (reset)
      s_reg.st == rshc_pkg::RSHC_UPD && s_reg.stats_en && !do_clear
      && !s_reg.pf2 && s_reg.dchan[0] == s_reg.ch && s_reg.seen[0]
      && $signed(rv) > $signed(s_reg.mx[0])
      |=> s_reg.mx[0] == $past(rv);
  endproperty
  a_max: assert property (p_max) else $error("max not replaced");

  property p_dev;
    @(posedge clk) disable iff (reset)
      s_reg.st == rshc_pkg::RSHC_UPD && s_reg.unit != cunit && !do_clear
      && !s_reg.pf2 |=> $stable(s_reg.dv);
  endproperty
  a_dev: assert property (p_dev) else $error("deviation updated");

  property p_filt;
    @(posedge clk) disable iff (reset)
      smp_valid && smp_ready && s_reg.filt_en[smp_chan]
      && !(wr_en && addr == `RSHC_A_CTRL)
      ##1 !(wr_en && addr == `RSHC_A_CTRL)
      |=> ##1 s_reg.rdg[s_reg.ch] == avg;
  endproperty
  a_filt: assert property (p_filt) else $error("average not used");
endmodule : rshc_core

// ### rtl/rshc_heater.sv
`timescale 1ns/1ps
`include "rshc_map.svh"
// heater mix, range scale and bar graph marker
module rshc_heater #(
  parameter int SEGS      = 10,
  parameter int BLINK_CYC = `RSHC_BLINK_CYC
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              gain_zero,
  input  wire logic [6:0]        manual,
  input  wire logic signed [7:0] pid_out,
  input  wire logic [2:0]        range,
  output logic      [19:0]       heater_pwr,
  output logic      [SEGS-1:0]   bar_blink
);
  localparam int CW = $clog2(BLINK_CYC + 1);
  typedef struct packed {
    logic [19:0]   pwr;
    logic [CW-1:0] cnt;
    logic          on;
  } rshc_heat_t;
  rshc_heat_t s_reg, s_next;
  logic signed [8:0] mix;
  logic [6:0]        pct;
  logic [13:0]       scale;
  logic [31:0]       seg;

  // ----------------------------------------
  // output power
  // ----------------------------------------
  always_comb begin
    mix = gain_zero ? $signed({2'b00, manual})
        : $signed({2'b00, manual}) + 9'(pid_out);
    if (mix < 0) begin
      pct = 7'h00;
    end else if (mix > `RSHC_MAN_MAX) begin
      pct = 7'h64;
    end else begin
      pct = mix[6:0];
    end
    // output counted in millionths of full power
    unique case (rshc_pkg::rshc_range_t'(range))
      rshc_pkg::RSHC_R_MAX: scale = 14'h2710;
      rshc_pkg::RSHC_R_M1:  scale = 14'h03E8;
      rshc_pkg::RSHC_R_M2:  scale = 14'h0064;
      rshc_pkg::RSHC_R_M3:  scale = 14'h000A;
      rshc_pkg::RSHC_R_M4:  scale = 14'h0001;
      default:              scale = 14'h0000;
    endcase
    s_next = s_reg;
    s_next.pwr = 20'(pct * scale);
    // half period of the marker blink
    if (s_reg.cnt >= CW'(BLINK_CYC - 1)) begin
      s_next.cnt = '0;
      s_next.on  = ~s_reg.on;
    end else begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // marker segment from the manual setting, top segment at full scale
  always_comb begin
    seg = 32'(manual) * SEGS / 100;
    if (seg >= SEGS) begin
      seg = SEGS - 1;
    end
    bar_blink = s_reg.on ? SEGS'(1) << seg : '0;
  end

  assign heater_pwr = s_reg.pwr;

  property p_off;
    @(posedge clk) disable iff (reset)
      range == 3'h0 |=> heater_pwr == 20'h0;
  endproperty
  a_off: assert property (p_off) else $error("off range gives power");

  property p_gz;
    @(posedge clk) disable iff (reset)
      gain_zero && range == 3'h1 && manual <= 7'h64
      |=> heater_pwr == 20'($past(manual) * 14'h2710);
  endproperty
  a_gz: assert property (p_gz) else $error("zero gain not manual");
endmodule : rshc_heater

// ### rtl/rshc_hist.sv
`timescale 1ns/1ps
// reading history store, registered read
module rshc_hist #(
  parameter int DEPTH = 20,
  parameter int AW    = 5,
  parameter int W     = 16
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0]            rd;
  } rshc_hist_t;
  rshc_hist_t s_reg, s_next;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.rd = s_reg.mem[raddr];
    if (we) begin
      s_next.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rd;
endmodule : rshc_hist

// ### rtl/rshc_map.svh
`ifndef RSHC_MAP_SVH
`define RSHC_MAP_SVH

// ----------------------------------------
// register offsets (word index)
// ----------------------------------------
`define RSHC_A_CTRL  5'h00
`define RSHC_A_CMD   5'h01
`define RSHC_A_GAIN  5'h02
`define RSHC_A_RATE  5'h03
`define RSHC_A_RSET  5'h04
`define RSHC_A_SETPT 5'h05
`define RSHC_A_MAN   5'h06
`define RSHC_A_RANGE 5'h07
`define RSHC_A_STAT0 5'h08
`define RSHC_A_RDGA  5'h0E
`define RSHC_A_RDGB  5'h0F
`define RSHC_A_INFO  5'h10
// ----------------------------------------
// fields and limits
// ----------------------------------------
`define RSHC_B_STATS 0
`define RSHC_B_FILT  1
`define RSHC_B_DISP  3
`define RSHC_B_CCH   5
`define RSHC_B_CLEAR 0
`define RSHC_GAIN_MAX 10'h3E7
`define RSHC_RATE_MAX 10'h3DE
`define RSHC_ITC_MAX  10'h3DE
`define RSHC_ITC_NUM  10'h3E8
`define RSHC_FILT_N   4'hA
`define RSHC_SP_Q     17'sh00064
`define RSHC_MAN_MAX  9'sh064
`define RSHC_RST_GAIN 10'h000
`define RSHC_RST_MAN  7'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define RSHC_CLK_NS   10
`define RSHC_BLINK_MS 500
`define RSHC_BLINK_CYC (`RSHC_BLINK_MS * 1000000 / `RSHC_CLK_NS)
`endif

// ### rtl/rshc_pkg.sv
package rshc_pkg;
  // filter pipeline, one-hot
  typedef enum logic [2:0] {
    RSHC_IDLE = 3'h1,
    RSHC_RD   = 3'h2,
    RSHC_UPD  = 3'h4
  } rshc_state_t;
  // unit codes of a reading; below volts is a temperature scale
  typedef enum logic [2:0] {
    RSHC_U_K   = 3'h0,
    RSHC_U_C   = 3'h1,
    RSHC_U_F   = 3'h2,
    RSHC_U_V   = 3'h3,
    RSHC_U_OHM = 3'h4,
    RSHC_U_NF  = 3'h5
  } rshc_unit_t;
  // heater range keys
  typedef enum logic [2:0] {
    RSHC_R_OFF = 3'h0,
    RSHC_R_MAX = 3'h1,
    RSHC_R_M1  = 3'h2,
    RSHC_R_M2  = 3'h3,
    RSHC_R_M3  = 3'h4,
    RSHC_R_M4  = 3'h5
  } rshc_range_t;
endpackage : rshc_pkg

// ### testbench/rshc_panel_model.sv
`timescale 1ns/1ps
// --------------------------------------
// sensor feed and pid stage stand-in
// --------------------------------------
module rshc_panel_model (
  input  wire logic         clk,
  input  wire logic         smp_ready,
  output logic              smp_valid,
  output logic              smp_chan,
  output logic       [15:0] smp_data,
  output logic       [2:0]  smp_unit,
  output logic signed [7:0] pid_out
);
  // quiet bus at time zero
  initial begin
    smp_valid = 1'b0;
    smp_chan  = 1'b0;
    smp_data  = 16'h5A5A;
    smp_unit  = 3'h0;
    pid_out   = 8'sh00;
  end

  // hold the offer until ready is seen; after release the data lines
  // flip so a stale reading can never pass for a fresh one
  task automatic send(input logic ch, input logic [15:0] d,
                      input logic [2:0] u);
    @(posedge clk);
    smp_valid <= 1'b1;
    smp_chan  <= ch;
    smp_data  <= d;
    smp_unit  <= u;
    do @(negedge clk); while (smp_ready !== 1'b1);
    @(posedge clk);
    smp_valid <= 1'b0;
    smp_data  <= ~d;
    repeat (3) @(posedge clk);
  endtask : send

  // pid stage output, changed just after an edge
  task automatic set_pid(input logic signed [7:0] v);
    @(posedge clk);
    pid_out <= v;
  endtask : set_pid
endmodule : rshc_panel_model

// ### testbench/tb.sv
`timescale 1ns/1ps
`include "rshc_map.svh"
module tb;
  logic        clk;
  logic        reset;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic        power_fail;
  logic [15:0] rdata;
  logic        smp_valid;
  logic        smp_ready;
  logic        smp_chan;
  logic [15:0] smp_data;
  logic [2:0]  smp_unit;
  logic [7:0]  pid_out;
  logic [1:0]  filt_led;
  logic [9:0]  gain_out;
  logic [9:0]  rate_tc_s;
  logic [9:0]  int_tc_s;
  logic [15:0] setpoint_out;
  logic        ctrl_chan;
  logic [19:0] heater_pwr;
  logic [9:0]  bar_blink;
  int          mismatches;
  int          tests_run;
  int          cycles;
  int          n;
  logic [19:0] e;

  rshc_core #(.SEGS(10), .BLINK_CYC(4)) dut (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .smp_chan(smp_chan), .smp_data(smp_data), .smp_unit(smp_unit),
    .pid_out(pid_out), .power_fail(power_fail), .filt_led(filt_led),
    .gain_out(gain_out), .rate_tc_s(rate_tc_s), .int_tc_s(int_tc_s),
    .setpoint_out(setpoint_out), .ctrl_chan(ctrl_chan),
    .heater_pwr(heater_pwr), .bar_blink(bar_blink));

  rshc_panel_model src (.clk(clk), .smp_ready(smp_ready),
    .smp_valid(smp_valid), .smp_chan(smp_chan), .smp_data(smp_data),
    .smp_unit(smp_unit), .pid_out(pid_out));

  // ----------------------------------------
  // clock, watchdog and shared tasks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // a hung handshake ends the run as a failure
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, input logic [19:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk(20'(rdata), exp);
  endtask : rd

  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic stat3(input logic [4:0] b, input logic [19:0] mx,
                       input logic [19:0] mn, input logic [19:0] dv);
    rd(b, mx);
    rd(5'(b + 5'h01), mn);
    rd(5'(b + 5'h02), dv);
  endtask : stat3

  task automatic heat(input logic [15:0] man, input logic [15:0] g,
                      input logic [15:0] rg, input logic signed [7:0] p,
                      input logic [19:0] exp);
    wr(`RSHC_A_MAN, man);
    wr(`RSHC_A_GAIN, g);
    wr(`RSHC_A_RANGE, rg);
    src.set_pid(p);
    settle();
    chk(heater_pwr, exp);
  endtask : heat

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    addr = 5'h00;
    wdata = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    power_fail = 1'b0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(`RSHC_A_GAIN, 20'h0);
    rd(`RSHC_A_RANGE, 20'h0);
    rd(5'h1F, 20'h0);
    // parameters: clamp and derived time constants
    wr(`RSHC_A_GAIN, 16'h03E8);
    rd(`RSHC_A_GAIN, 20'h003E7);
    chk(20'(gain_out), 20'h003E7);
    wr(`RSHC_A_RATE, 16'h03DE);
    settle();
    chk(20'(rate_tc_s), 20'h003DE);
    wr(`RSHC_A_RSET, 16'h0014);
    settle();
    chk(20'(int_tc_s), 20'h00032);
    wr(`RSHC_A_RSET, 16'h0001);
    settle();
    chk(20'(int_tc_s), 20'h003DE);
    wr(`RSHC_A_RSET, 16'h03E7);
    settle();
    chk(20'(int_tc_s), 20'h00001);
    // setpoint quantising follows the control channel unit
    src.send(1'b0, 16'h0064, rshc_pkg::RSHC_U_K);
    wr(`RSHC_A_SETPT, 16'h04D2);
    rd(`RSHC_A_SETPT, 20'h004B0);
    wr(`RSHC_A_SETPT, 16'hFB2E);
    settle();
    chk(20'(setpoint_out), 20'h0FB50);
    src.send(1'b0, 16'h0064, rshc_pkg::RSHC_U_V);
    wr(`RSHC_A_SETPT, 16'h04D2);
    rd(`RSHC_A_SETPT, 20'h004D2);
    wr(`RSHC_A_SETPT, 16'h0000);
    // heater mix, every range key, off override
    heat(16'h0032, 16'h0000, 16'h0001, 8'sh14, 20'h7A120);
    heat(16'h0032, 16'h0001, 16'h0001, 8'sh14, 20'hAAE60);
    heat(16'h0032, 16'h0001, 16'h0001, -8'sh14, 20'h493E0);
    e = 20'h7A120;
    for (int r = 1; r <= 5; r++) begin
      heat(16'h0032, 16'h0000, 16'(r), 8'sh00, e);
      e = e / 20'h0000A;
    end
    heat(16'h0032, 16'h0001, 16'h0000, 8'sh14, 20'h0);
    heat(16'h0032, 16'h0001, 16'h0006, 8'sh14, 20'h0);
    // blinking marker: one segment, and it goes dark again
    for (n = 0; n < 40 && bar_blink === 10'h000; n++) @(negedge clk);
    chk(20'(bar_blink), 20'h00020);
    for (n = 0; n < 40 && bar_blink !== 10'h000; n++) @(negedge clk);
    chk(20'(bar_blink), 20'h0);
    // filter tied to channel, lamp follows the shown channel
    wr(`RSHC_A_CTRL, 16'h0012);
    settle();
    chk(20'(filt_led), 20'h1);
    wr(`RSHC_A_CTRL, 16'h000A);
    settle();
    chk(20'(filt_led), 20'h2);
    for (int i = 0; i < 12; i++)
      src.send(1'b0, 16'(i * 100), rshc_pkg::RSHC_U_K);
    rd(`RSHC_A_RDGA, 20'h0028A);
    src.send(1'b1, 16'h0309, rshc_pkg::RSHC_U_K);
    rd(`RSHC_A_RDGB, 20'h00309);
    // statistics: track, freeze, clear, units, power loss
    wr(`RSHC_A_CTRL, 16'h0011);
    wr(`RSHC_A_CMD, 16'h0001);
    src.send(1'b0, 16'h01F4, rshc_pkg::RSHC_U_K);
    src.send(1'b0, 16'hFED4, rshc_pkg::RSHC_U_K);
    src.send(1'b0, 16'h00C8, rshc_pkg::RSHC_U_K);
    stat3(`RSHC_A_STAT0, 20'h001F4, 20'h0FED4, 20'h001F4);
    wr(`RSHC_A_CTRL, 16'h0010);
    src.send(1'b0, 16'h0384, rshc_pkg::RSHC_U_K);
    stat3(`RSHC_A_STAT0, 20'h001F4, 20'h0FED4, 20'h001F4);
    // clear while enabled, so a kept enable is visible
    wr(`RSHC_A_CTRL, 16'h0011);
    wr(`RSHC_A_CMD, 16'h0001);
    stat3(`RSHC_A_STAT0, 20'h0, 20'h0, 20'h0);
    rd(`RSHC_A_CTRL, 20'h00011);
    src.send(1'b0, 16'h0384, rshc_pkg::RSHC_U_K);
    stat3(`RSHC_A_STAT0, 20'h00384, 20'h00384, 20'h00384);
    src.send(1'b1, 16'h0190, rshc_pkg::RSHC_U_V);
    stat3(5'(`RSHC_A_STAT0 + 5'h03), 20'h00190, 20'h00190, 20'h0);
    @(posedge clk);
    power_fail <= 1'b1;
    settle();
    settle();
    rd(`RSHC_A_CTRL, 20'h00010);
    stat3(`RSHC_A_STAT0, 20'h0, 20'h0, 20'h0);
    conclude();
  end
endmodule : tb
